// File: psfc_pkg.sv
// Package for the packed-SIMD prefix and floating-point state control block
package psfc_pkg;
  localparam int unsigned NUM_REGS       = 8;
  localparam int unsigned REG_IDX_W      = 3;
  localparam int unsigned FP_REG_W       = 80;
  localparam int unsigned SIMD_W         = 64;
  localparam int unsigned TAG_W          = 16;
  localparam int unsigned FEATURE_BIT    = 23;
  localparam int unsigned TOP_LSB        = 11;
  localparam int unsigned TOP_W          = 3;
  localparam logic [7:0]  PFX_ADDR_SIZE  = 8'h67;
  localparam logic [7:0]  PFX_OPND_SIZE  = 8'h66;
  localparam logic [7:0]  PFX_LOCK       = 8'hf0;
  localparam logic [1:0]  TAG_VALID      = 2'h0;
  localparam logic [1:0]  TAG_EMPTY      = 2'h3;
  localparam logic [15:0] TAG_ALL_VALID  = 16'h0000;
  localparam logic [15:0] TAG_ALL_EMPTY  = 16'hffff;
  localparam logic [15:0] FP_STAT_RESET  = 16'h0000;
  localparam logic [15:0] FP_CTRL_RESET  = 16'h037f;
  localparam logic [15:0] SIMD_EXP_ONES  = 16'hffff;
  localparam logic [31:0] FEATURE_RESET  = 32'h0000_0000;
  localparam logic [5:0]  FP_EXC_MASK_ALL = 6'h3f;
  // Default NaN: sign and exponent all ones, quiet indefinite mantissa
  localparam logic [79:0] FP_NAN_VALUE   = 80'hffff_c000_0000_0000_0000;

  typedef enum logic [2:0] {
    PSFC_OP_NONE  = 3'h0,
    PSFC_OP_SIMD  = 3'h1,
    PSFC_OP_EMPTY = 3'h2,
    PSFC_OP_IDENT = 3'h3,
    PSFC_OP_FP    = 3'h4
  } psfc_op_t;

  typedef struct packed {
    logic                 valid;
    psfc_op_t             op;
    logic                 has_mem;
    logic                 pfx_addr_size;
    logic                 pfx_opnd_size;
    logic                 pfx_seg;
    logic [2:0]           seg_sel;
    logic                 pfx_rep;
    logic                 pfx_lock;
    logic                 dst_write;
    logic [2:0]           dst_reg;
    logic [2:0]           src_reg;
    logic [63:0]          wdata;
  } psfc_instr_t;

  typedef struct packed {
    logic       valid;
    logic       use_addr32_flip;
    logic       use_seg;
    logic [2:0] seg_sel;
  } psfc_mem_ctl_t;

  typedef enum logic [1:0] {
    PSFC_ST_IDLE  = 2'b00,
    PSFC_ST_EXEC  = 2'b01,
    PSFC_ST_WAIT  = 2'b11
  } psfc_state_t;
endpackage

// File: psfc_regfile.sv
// Shared 80-bit register storage seen as stack registers or packed-SIMD registers
`timescale 1ns/1ps
`default_nettype none
module psfc_regfile #(
  parameter int unsigned NREGS = 8
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 simd_we,
  input  wire logic [2:0]           simd_idx,
  input  wire logic [63:0]          simd_wdata,
  input  wire logic                 fp_we,
  input  wire logic [2:0]           fp_idx,
  input  wire logic [79:0]          fp_wdata,
  input  wire logic [2:0]           rd_idx,
  output logic      [79:0]          rd_data
);
  if (NREGS != psfc_pkg::NUM_REGS) begin : g_bad_nregs
    $error("psfc_regfile: NREGS must be 8");
  end

  logic [79:0] regs [NREGS];
  // A SIMD write always pre-empts an FP write to the same cycle
  wire  [79:0] simd_word = {psfc_pkg::SIMD_EXP_ONES, simd_wdata};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NREGS; i++) begin
        regs[i] <= '0;
      end
    end else if (simd_we) begin
      regs[simd_idx] <= simd_word;
    end else if (fp_we) begin
      regs[fp_idx] <= fp_wdata;
    end
  end

  assign rd_data = regs[rd_idx];
endmodule
`default_nettype wire

// File: psfc_core.sv
// Prefix decoder and floating-point state control for packed-SIMD instructions
//
// Behaviour
// - Address-size and segment prefixes act only when a memory operand exists.
// - Operand-size and repeat prefixes are ignored on SIMD instructions.
// - Lock prefix on a SIMD instruction raises invalid opcode.
// - Identify instruction reports bit 23 set when SIMD is supported.
// - Bit 23 stays reported even while emulation control is set.
// - Emulation control set makes any SIMD instruction raise invalid opcode.
// - Each SIMD instruction except empty-state sets every tag to valid.
// - Empty-state instruction marks the whole tag word empty.
// - Each SIMD instruction forces the stack top pointer to zero.
// - SIMD register writes fill the aliased exponent with ones.
// - SIMD registers share storage with floating-point registers.
// - SIMD registers are directly addressed by instruction fields.
// - FP use of a SIMD-valid stack raises or masks an FP exception.
// - When masked, a NaN with all-ones exponent is pushed, execution continues.
// - Empty tag encoding is binary 11 in every field.
// - SIMD write fills bits 63-0 with data, bits 79-64 with ones.
// - Pending FP exception makes the next SIMD instruction raise numeric error.
//
`timescale 1ns/1ps
`default_nettype none
module psfc_core #(
  parameter bit          SIMD_SUPPORTED = 1'b1,
  parameter logic [31:0] FEATURE_BASE   = psfc_pkg::FEATURE_RESET
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire psfc_pkg::psfc_instr_t instr,
  input  wire logic                  fp_emulation_control_bit,
  input  wire logic                  fp_exc_raised,
  input  wire logic                  handler_done,
  output logic                       instr_ready,
  output logic                       invalid_opcode_req,
  output logic                       numeric_error_req,
  output logic                       fp_exception_event,
  output psfc_pkg::psfc_mem_ctl_t    mem_ctl,
  output logic [31:0]                feature_flag_result_word,
  output logic                       feature_valid,
  output logic [15:0]                fp_tag_word,
  output logic [2:0]                 fp_stack_top_pointer,
  output logic [79:0]                rd_data,
  output logic                       retire
);
  // Elaboration checks: the field layout below assumes these package sizes
  if (psfc_pkg::FEATURE_BIT >= 32) begin : g_bad_feature
    $error("psfc_core: feature bit out of range");
  end
  if (psfc_pkg::TAG_W != 2 * psfc_pkg::NUM_REGS) begin : g_bad_tag
    $error("psfc_core: tag word needs two bits per register");
  end
  if (psfc_pkg::TOP_W != psfc_pkg::REG_IDX_W) begin : g_bad_top
    $error("psfc_core: top pointer must index every register");
  end

  psfc_pkg::psfc_state_t state;
  psfc_pkg::psfc_state_t next_state;
  logic        fp_exc_pending;
  logic [5:0]  fp_exc_mask;
  logic [79:0] rf_rd;
  logic        simd_owned;

  // Decode of the offered instruction
  wire is_simd   = instr.valid && (instr.op == psfc_pkg::PSFC_OP_SIMD);
  wire is_empty  = instr.valid && (instr.op == psfc_pkg::PSFC_OP_EMPTY);
  wire is_ident  = instr.valid && (instr.op == psfc_pkg::PSFC_OP_IDENT);
  wire is_fp     = instr.valid && (instr.op == psfc_pkg::PSFC_OP_FP);
  wire simd_cls  = is_simd || is_empty;
  wire accept    = (state == psfc_pkg::PSFC_ST_IDLE);

  wire lock_bad  = simd_cls && instr.pfx_lock;
  wire emu_bad   = simd_cls && fp_emulation_control_bit;
  wire ud_hit    = accept && (lock_bad || emu_bad);
  // Invalid opcode outranks the pending numeric error
  wire mf_hit    = accept && simd_cls && !ud_hit && fp_exc_pending;
  wire simd_go   = accept && simd_cls && !ud_hit && !fp_exc_pending;
  wire simd_wr   = simd_go && is_simd && instr.dst_write;

  // Operand-size and repeat prefixes are deliberately never read here
  wire mem_go    = simd_go && instr.has_mem;

  // FP op on registers left valid by SIMD code
  wire fp_dirty  = accept && is_fp && (fp_tag_word == psfc_pkg::TAG_ALL_VALID)
                   && simd_owned;
  wire fp_masked = &fp_exc_mask;
  // Masked fault: the internal handler pushes a NaN and the FP op still completes
  wire nan_push  = fp_dirty && fp_masked;
  wire ident_go  = accept && is_ident;

  wire [31:0] feature_word = SIMD_SUPPORTED ?
      (FEATURE_BASE | (32'h0000_0001 << psfc_pkg::FEATURE_BIT)) :
      (FEATURE_BASE & ~(32'h0000_0001 << psfc_pkg::FEATURE_BIT));

  // One two-bit tag per physical register; a SIMD op rewrites all of them at once
  wire [15:0] next_tag;
  for (genvar g = 0; g < psfc_pkg::NUM_REGS; g++) begin : g_tag
    assign next_tag[2*g +: 2] = !simd_go ? fp_tag_word[2*g +: 2] :
        (is_empty ? psfc_pkg::TAG_EMPTY : psfc_pkg::TAG_VALID);
  end
  wire [2:0]  push_idx = fp_stack_top_pointer - 3'h1;

  // Next values of the registered outputs; each result is latched on its taking edge and shows right after it
  wire        next_invalid_opcode_req       = ud_hit;
  wire        next_numeric_error_req        = mf_hit;
  wire        next_fp_exception_event       = fp_dirty && !fp_masked;
  psfc_pkg::psfc_mem_ctl_t next_mem_ctl;
  // Register-only ops leave the memory controls at zero, so their prefixes have no effect
  assign next_mem_ctl = {mem_go, mem_go && instr.pfx_addr_size, mem_go && instr.pfx_seg,
                         mem_go ? instr.seg_sel : 3'h0};
  wire [31:0] next_feature_flag_result_word = ident_go ? feature_word : 32'h0000_0000;
  wire        next_feature_valid            = ident_go;
  wire [79:0] next_rd_data                  = simd_go ? rf_rd : 80'h0;
  wire        next_retire                   = simd_go || ident_go || nan_push;
  wire        next_instr_ready              = (next_state == psfc_pkg::PSFC_ST_IDLE);

  always_comb begin
    next_state = state;
    unique case (state)
      psfc_pkg::PSFC_ST_IDLE: begin
        if (mf_hit) begin
          next_state = psfc_pkg::PSFC_ST_WAIT;
        end
      end
      psfc_pkg::PSFC_ST_EXEC: begin
        next_state = psfc_pkg::PSFC_ST_IDLE;
      end
      psfc_pkg::PSFC_ST_WAIT: begin
        if (handler_done) begin
          next_state = psfc_pkg::PSFC_ST_IDLE;
        end
      end
      default: next_state = psfc_pkg::PSFC_ST_IDLE;
    endcase
  end

  psfc_regfile #(
    .NREGS (psfc_pkg::NUM_REGS)
  ) u_regs (
    .clock      (clock),
    .rst_n      (rst_n),
    .simd_we    (simd_wr),
    .simd_idx   (instr.dst_reg),
    .simd_wdata (instr.wdata),
    .fp_we      (nan_push),
    .fp_idx     (push_idx),
    .fp_wdata   (psfc_pkg::FP_NAN_VALUE),
    .rd_idx     (instr.src_reg),
    .rd_data    (rf_rd)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= psfc_pkg::PSFC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Pending FP exception: a new raise wins over the clear by the handler
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fp_exc_pending <= 1'b0;
    end else if (fp_exc_raised || (fp_dirty && !fp_masked)) begin
      fp_exc_pending <= 1'b1;
    end else if (state == psfc_pkg::PSFC_ST_WAIT && handler_done) begin
      fp_exc_pending <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fp_exc_mask <= psfc_pkg::FP_CTRL_RESET[5:0];
    end else begin
      fp_exc_mask <= fp_exc_mask;
    end
  end

  // Tracks that the all-valid tag came from SIMD code, not from FP loads
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      simd_owned <= 1'b0;
    end else if (simd_go) begin
      simd_owned <= is_simd;
    end else if (fp_dirty) begin
      simd_owned <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fp_tag_word          <= psfc_pkg::TAG_ALL_EMPTY;
      fp_stack_top_pointer <= psfc_pkg::FP_STAT_RESET[13:11];
    end else if (simd_go) begin
      fp_tag_word          <= next_tag;
      fp_stack_top_pointer <= 3'h0;
    end else if (fp_dirty && fp_masked) begin
      fp_stack_top_pointer <= push_idx;
    end
  end

  // Both invalid-opcode causes leave through this single request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      invalid_opcode_req <= 1'b0;
    end else begin
      invalid_opcode_req <= next_invalid_opcode_req;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      numeric_error_req <= 1'b0;
    end else begin
      numeric_error_req <= next_numeric_error_req;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fp_exception_event <= 1'b0;
    end else begin
      fp_exception_event <= next_fp_exception_event;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_ctl <= '0;
    end else begin
      mem_ctl <= next_mem_ctl;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      feature_flag_result_word <= psfc_pkg::FEATURE_RESET;
    end else begin
      feature_flag_result_word <= next_feature_flag_result_word;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      feature_valid <= 1'b0;
    end else begin
      feature_valid <= next_feature_valid;
    end
  end

  // Read data is the old register value, so a write in the same op does not show
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      retire <= 1'b0;
    end else begin
      retire <= next_retire;
    end
  end

  // Low through reset and the first cycle after it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      instr_ready <= 1'b0;
    end else begin
      instr_ready <= next_instr_ready;
    end
  end
endmodule
`default_nettype wire

// File: psfc_core_asserts.sv
// Checker for the packed-SIMD prefix and floating-point state control core
`timescale 1ns/1ps
`default_nettype none
module psfc_core_asserts (
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire psfc_pkg::psfc_instr_t   instr,
  input wire logic                    fp_emulation_control_bit,
  input wire logic                    instr_ready,
  input wire logic                    invalid_opcode_req,
  input wire logic                    numeric_error_req,
  input wire logic                    retire,
  input wire logic                    feature_valid,
  input wire logic [31:0]             feature_flag_result_word,
  input wire logic [15:0]             fp_tag_word,
  input wire logic [2:0]              fp_stack_top_pointer,
  input wire psfc_pkg::psfc_mem_ctl_t mem_ctl
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic take = instr.valid && instr_ready;
  wire logic simd = instr.op == psfc_pkg::PSFC_OP_SIMD;
  wire logic emp  = instr.op == psfc_pkg::PSFC_OP_EMPTY;
  wire logic bad  = instr.pfx_lock || fp_emulation_control_bit;
  lock_reject_a: assert property (take && (simd || emp) && instr.pfx_lock
    |=> invalid_opcode_req && $stable(fp_tag_word)) else $error("lock prefix not refused");
  emul_reject_a: assert property (take && (simd || emp) && fp_emulation_control_bit
    |=> invalid_opcode_req && $stable(fp_tag_word)) else $error("emulation not refused");
  simd_tag_a: assert property (take && simd && !bad |=> numeric_error_req
    || (fp_tag_word == psfc_pkg::TAG_ALL_VALID && fp_stack_top_pointer == 3'h0))
    else $error("tag or top wrong after simd op");
  empty_tag_a: assert property (take && emp && !bad |=> numeric_error_req
    || fp_tag_word == psfc_pkg::TAG_ALL_EMPTY) else $error("tag not empty after empty op");
  ident_flag_a: assert property (take && instr.op == psfc_pkg::PSFC_OP_IDENT
    |=> feature_valid && feature_flag_result_word[23]) else $error("feature bit missing");
  mem_pass_a: assert property (take && simd && !bad && instr.has_mem |=> numeric_error_req
    || (mem_ctl.valid && mem_ctl.use_addr32_flip == $past(instr.pfx_addr_size)
    && mem_ctl.use_seg == $past(instr.pfx_seg))) else $error("memory prefixes lost");
  mem_ignore_a: assert property (take && !instr.has_mem |=> !mem_ctl.valid)
    else $error("prefix acted without memory operand");
  single_req_a: assert property (invalid_opcode_req |-> !retire && !numeric_error_req)
    else $error("refused op also executed");
  cover property (take && simd && !bad);
  cover property (invalid_opcode_req);
  cover property (numeric_error_req);
endmodule
bind psfc_core psfc_core_asserts psfc_core_asserts_inst (.clock, .rst_n, .instr,
  .fp_emulation_control_bit, .instr_ready, .invalid_opcode_req, .numeric_error_req,
  .retire, .feature_valid, .feature_flag_result_word, .fp_tag_word,
  .fp_stack_top_pointer, .mem_ctl);
`default_nettype wire

// File: psfc_fpu_model.sv
// Floating-point unit model: reports faults and runs the numeric-error handler
`timescale 1ns/1ps
`default_nettype none
module psfc_fpu_model #(
  parameter int unsigned HANDLER_CYCLES = 4
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic raise,
  input  wire logic numeric_error_req,
  output logic      fp_exc_raised,
  output logic      handler_done
);
  int unsigned cnt;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fp_exc_raised <= 1'b0;
      handler_done <= 1'b0;
      cnt <= 0;
    end else begin
      fp_exc_raised <= raise;
      // Handler takes a while, so the core must hold off until it returns
      handler_done <= (cnt == 1);
      if (numeric_error_req) cnt <= HANDLER_CYCLES;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// File: test_psfc_core.sv
// Self-checking testbench for the packed-SIMD state control core
`timescale 1ns/1ps
`default_nettype none
module test_psfc_core;
  typedef struct packed {
    psfc_pkg::psfc_instr_t i;
    logic                  emu;
    logic                  inv;
    logic [15:0]           tag;
  } psfc_row_t;
  logic clock = 1'b0, rst_n = 1'b0, emu = 1'b0, raise = 1'b0;
  psfc_pkg::psfc_instr_t instr = '0;
  logic rdy, inv, nerr, fpev, fval, ret, exc, hdone;
  logic [31:0] fword;
  logic [15:0] tag;
  logic [2:0] top;
  logic [79:0] rd;
  psfc_pkg::psfc_mem_ctl_t mem;
  int n_errors = 0, checks_done = 0;
  psfc_row_t rows [8];
  localparam logic [63:0] DATA = 64'h0123_4567_89ab_cde0;
  always #50 clock = ~clock;
  psfc_core psfc_core_inst (.clock, .rst_n, .instr, .fp_emulation_control_bit(emu),
    .fp_exc_raised(exc), .handler_done(hdone), .instr_ready(rdy), .invalid_opcode_req(inv),
    .numeric_error_req(nerr), .fp_exception_event(fpev), .mem_ctl(mem),
    .feature_flag_result_word(fword), .feature_valid(fval), .fp_tag_word(tag),
    .fp_stack_top_pointer(top), .rd_data(rd), .retire(ret));
  psfc_fpu_model psfc_fpu_model_inst (.clock, .rst_n, .raise, .numeric_error_req(nerr),
    .fp_exc_raised(exc), .handler_done(hdone));
  task chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Offer one instruction once idle, then sample the results a step after the taking edge
  task issue(input psfc_pkg::psfc_instr_t i, input logic em);
    int k;
    k = 0;
    while (rdy !== 1'b1 && k < 50) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (rdy !== 1'b1) begin
      n_errors++;
      $display("Error instr_ready expected 1 seen %b", rdy);
    end
    @(posedge clock);
    instr <= i;
    emu <= em;
    @(posedge clock);
    instr <= '0;
    #1;
  endtask
  function automatic psfc_row_t mk(input psfc_pkg::psfc_op_t op,
                                   input logic lk, mm, em, iv, input logic [15:0] tg);
    psfc_row_t r;
    r = '0;
    r.i.valid = 1'b1;
    r.i.op = op;
    r.i.has_mem = mm;
    // Memory prefixes ride on every row: register-only rows must ignore them
    r.i.pfx_addr_size = 1'b1;
    r.i.pfx_seg = 1'b1;
    r.i.seg_sel = 3'h5;
    r.i.pfx_opnd_size = 1'b1;
    r.i.pfx_rep = 1'b1;
    r.i.pfx_lock = lk;
    r.i.dst_write = 1'b1;
    r.i.dst_reg = {mm, 2'h3};
    r.i.src_reg = 3'h3;
    // Refused ops carry different data so a stray write would show later
    r.i.wdata = DATA | {62'h0, em, lk};
    r.emu = em;
    r.inv = iv;
    r.tag = tg;
    return r;
  endfunction
  initial begin
    #(100 * 3000);
    n_errors++;
    end_of_test;
  end
  initial begin
    psfc_row_t s;
    rows = '{mk(psfc_pkg::PSFC_OP_SIMD, 0, 0, 0, 0, 16'h0000),
             mk(psfc_pkg::PSFC_OP_EMPTY, 0, 0, 0, 0, 16'hffff),
             mk(psfc_pkg::PSFC_OP_SIMD, 1, 0, 0, 1, 16'hffff),
             mk(psfc_pkg::PSFC_OP_SIMD, 0, 0, 1, 1, 16'hffff),
             mk(psfc_pkg::PSFC_OP_EMPTY, 0, 0, 1, 1, 16'hffff),
             mk(psfc_pkg::PSFC_OP_IDENT, 0, 0, 1, 0, 16'hffff),
             mk(psfc_pkg::PSFC_OP_SIMD, 0, 1, 0, 0, 16'h0000),
             mk(psfc_pkg::PSFC_OP_EMPTY, 1, 0, 0, 1, 16'h0000)};
    repeat (8) @(posedge clock);
    #1;
    chk("reset_tag", psfc_pkg::TAG_ALL_EMPTY, tag);
    chk("reset_ready", 1'b0, rdy);
    @(posedge clock);
    rst_n <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      issue(rows[n].i, rows[n].emu);
      chk("invalid", rows[n].inv, inv);
      chk("tag", rows[n].tag, tag);
      if (rows[n].i.op == psfc_pkg::PSFC_OP_IDENT) begin
        chk("feature", 1'b1, fword[23]);
        chk("feature_valid", 1'b1, fval);
      end else chk("feature_idle", 1'b0, fval);
      if (rows[n].i.has_mem) begin
        chk("mem_ctl", {3'h7, 3'h5}, mem);
        chk("alias", {psfc_pkg::SIMD_EXP_ONES, DATA}, rd);
      end else chk("mem_idle", 6'h0, mem);
    end
    // Floating-point op on a stack left valid: masked fault pushes a NaN
    s = mk(psfc_pkg::PSFC_OP_FP, 0, 0, 0, 0, 16'h0);
    issue(s.i, 1'b0);
    chk("nan_top", 3'h7, top);
    chk("fp_event", 1'b0, fpev);
    s = mk(psfc_pkg::PSFC_OP_SIMD, 0, 0, 0, 0, 16'h0);
    s.i.dst_write = 1'b0;
    s.i.src_reg = 3'h7;
    issue(s.i, 1'b0);
    chk("nan_alias", psfc_pkg::FP_NAN_VALUE, rd);
    chk("top_zero", 3'h0, top);
    @(posedge clock);
    raise <= 1'b1;
    @(posedge clock);
    raise <= 1'b0;
    s.i.src_reg = 3'h3;
    issue(s.i, 1'b0);
    chk("numeric", 1'b1, nerr);
    chk("held", 1'b0, ret);
    issue(s.i, 1'b0);
    chk("resumed", 1'b1, ret);
    s = mk(psfc_pkg::PSFC_OP_EMPTY, 0, 0, 0, 0, 16'h0);
    issue(s.i, 1'b0);
    chk("emptied", psfc_pkg::TAG_ALL_EMPTY, tag);
    // Mid-run reset after a SIMD write: tags and shared registers return to reset values
    s = mk(psfc_pkg::PSFC_OP_SIMD, 0, 0, 0, 0, 16'h0);
    issue(s.i, 1'b0);
    chk("pre_reset_tag", psfc_pkg::TAG_ALL_VALID, tag);
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    #1;
    chk("rerun_tag", psfc_pkg::TAG_ALL_EMPTY, tag);
    chk("rerun_ready", 1'b0, rdy);
    @(posedge clock);
    rst_n <= 1'b1;
    issue(s.i, 1'b0);
    chk("rerun_regs", 80'h0, rd);
    chk("rerun_simd", psfc_pkg::TAG_ALL_VALID, tag);
    end_of_test;
  end
endmodule
`default_nettype wire
